// ===== hw/pad_ctrl_defines.vh
// Offsets, field positions and reset values of the pad configuration bank.
// Assumes it is included by the bank and by nothing that redefines these names.
`ifndef PAD_CTRL_DEFINES_VH
`define PAD_CTRL_DEFINES_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define PAD34_CONFIG_OFFSET 12'h088
`define PAD35_CONFIG_OFFSET 12'h08c
`define PAD36_CONFIG_OFFSET 12'h090
`define PAD37_CONFIG_OFFSET 12'h094

// ****************************************************************
// Field positions
// ****************************************************************
`define OUTPUT_FUNCTION_SELECT_LSB 0
`define OUTPUT_FUNCTION_SELECT_MSB 1
`define CTRL_SRC_LSB 3
`define CTRL_SRC_MSB 4
`define DRIVE_DIS_N_BIT 5
`define PULL_LSB 6
`define PULL_MSB 7
`define STRENGTH_LSB 8
`define STRENGTH_MSB 9
`define SLEW_FAST_BIT 10
`define RX_EN_BIT 11
`define HYST_BIT 12

// Writable bits: 12:3 and 1:0
`define PAD_WRITE_MASK 32'h00001ffb

// ****************************************************************
// Codes
// ****************************************************************
`define CTRL_SRC_LOCAL 2'h0
`define CTRL_SRC_PERIPH 2'h1
`define CTRL_SRC_FABRIC 2'h2
`define ENGINE_FUNCTION_CODE 2'h2

// ****************************************************************
// Reset values
// ****************************************************************
`define PAD_RESET_SRC_PERIPH 32'h00000128
`define PAD_RESET_SRC_LOCAL 32'h00000120

`endif

// ===== hw/pad_route.v
// One pad's control router: picks the owner of the pad controls.
// Assumes the register value is already masked; outputs are registered.
`timescale 1ns/1ps
`include "pad_ctrl_defines.vh"

module pad_route #(
  parameter ENGINE_OVERRIDE = 1'b0
) (
  input wire i_clk_sys,
  input wire i_nrst,
  input wire [31:0] i_cfg,
  input wire [10:0] i_periph_ctrl,
  input wire [10:0] i_fabric_ctrl,
  input wire [10:0] i_engine_ctrl,
  output reg [10:0] o_pad_ctrl,
  output reg [1:0] o_output_function_select
);

  // ****************************************************************
  // Control bundle: {hyst, rx_en, slew, strength[1:0], pull[1:0], dis_n}
  // ****************************************************************
  wire [1:0] src;
  wire [10:0] local_ctrl;
  reg [10:0] next_pad_ctrl;

  assign src = i_cfg[`CTRL_SRC_MSB:`CTRL_SRC_LSB];
  // Top three bits unused by the local source, held at zero
  assign local_ctrl = {3'h0, i_cfg[`HYST_BIT], i_cfg[`RX_EN_BIT], i_cfg[`SLEW_FAST_BIT],
    i_cfg[`STRENGTH_MSB:`STRENGTH_LSB], i_cfg[`PULL_MSB:`PULL_LSB],
    i_cfg[`DRIVE_DIS_N_BIT]};

  always @* begin
    if (ENGINE_OVERRIDE &&
        i_cfg[`OUTPUT_FUNCTION_SELECT_MSB:`OUTPUT_FUNCTION_SELECT_LSB] ==
        `ENGINE_FUNCTION_CODE) begin
      next_pad_ctrl = i_engine_ctrl;
    end else begin
      case (src)
        `CTRL_SRC_LOCAL: next_pad_ctrl = local_ctrl;
        `CTRL_SRC_PERIPH: next_pad_ctrl = i_periph_ctrl;
        `CTRL_SRC_FABRIC: next_pad_ctrl = i_fabric_ctrl;
        // Unused code: park the pad safe, driver off
        default: next_pad_ctrl = 11'h001;
      endcase
    end
  end

  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pad_ctrl <= 11'h001;
      o_output_function_select <= 2'h0;
    end else begin
      o_pad_ctrl <= next_pad_ctrl;
      o_output_function_select <=
        i_cfg[`OUTPUT_FUNCTION_SELECT_MSB:`OUTPUT_FUNCTION_SELECT_LSB];
    end
  end

endmodule // pad_route

// ===== hw/pad_ctrl_bank.v
// Configuration bank for I/O pads 34 to 37 with control routing.
// Assumes a single-cycle strobe bus master on i_clk_sys, one strobe at a time.
`timescale 1ns/1ps
`include "pad_ctrl_defines.vh"

// Summary of operation
// - Bits 1:0 select pad output function
// - Bits 4:3 choose control owner
// - Local source applies register pad fields
// - Pads 35-37 function 2 hands engine control
// - Bit 5 low enables driver
// - Bits 7:6 pick Z, up, down, keeper
// - Bits 9:8 pick drive strength
// - Bit 10 high gives fast slew
// - Bit 11 enables input receiver
// - Bit 12 enables hysteresis input
module pad_ctrl_bank (
  input wire i_clk_sys,
  input wire i_nrst,
  input wire [11:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  input wire [43:0] i_periph_ctrl,
  input wire [43:0] i_fabric_ctrl,
  input wire [43:0] i_engine_ctrl,
  output wire [43:0] o_pad_ctrl,
  output wire [7:0] o_output_function_select
);

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  reg [31:0] pad34_config;
  reg [31:0] pad35_config;
  reg [31:0] pad36_config;
  reg [31:0] pad37_config;
  wire [31:0] wval;

  // Reserved bits never store, so they always read zero
  assign wval = i_wdata & `PAD_WRITE_MASK;

  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      // Pads 34 and 36 start owned by peripherals, 35 and 37 locally
      pad34_config <= `PAD_RESET_SRC_PERIPH;
      pad35_config <= `PAD_RESET_SRC_LOCAL;
      pad36_config <= `PAD_RESET_SRC_PERIPH;
      pad37_config <= `PAD_RESET_SRC_LOCAL;
    end else if (i_wr) begin
      case (i_addr)
        `PAD34_CONFIG_OFFSET: pad34_config <= wval;
        `PAD35_CONFIG_OFFSET: pad35_config <= wval;
        `PAD36_CONFIG_OFFSET: pad36_config <= wval;
        `PAD37_CONFIG_OFFSET: pad37_config <= wval;
        // Unmapped writes are dropped
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Read port: data valid the cycle after the strobe only
  // ****************************************************************
  reg [31:0] next_rdata;

  always @* begin
    next_rdata = 32'h00000000;
    if (i_rd) begin
      case (i_addr)
        `PAD34_CONFIG_OFFSET: next_rdata = pad34_config;
        `PAD35_CONFIG_OFFSET: next_rdata = pad35_config;
        `PAD36_CONFIG_OFFSET: next_rdata = pad36_config;
        `PAD37_CONFIG_OFFSET: next_rdata = pad37_config;
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 32'h00000000;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  // ****************************************************************
  // Per-pad routing; pad 34 has no engine override
  // ****************************************************************
  pad_route #(.ENGINE_OVERRIDE(1'b0)) u_pad34 (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_cfg(pad34_config),
    .i_periph_ctrl(i_periph_ctrl[10:0]),
    .i_fabric_ctrl(i_fabric_ctrl[10:0]),
    .i_engine_ctrl(i_engine_ctrl[10:0]),
    .o_pad_ctrl(o_pad_ctrl[10:0]),
    .o_output_function_select(o_output_function_select[1:0])
  );

  pad_route #(.ENGINE_OVERRIDE(1'b1)) u_pad35 (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_cfg(pad35_config),
    .i_periph_ctrl(i_periph_ctrl[21:11]),
    .i_fabric_ctrl(i_fabric_ctrl[21:11]),
    .i_engine_ctrl(i_engine_ctrl[21:11]),
    .o_pad_ctrl(o_pad_ctrl[21:11]),
    .o_output_function_select(o_output_function_select[3:2])
  );

  pad_route #(.ENGINE_OVERRIDE(1'b1)) u_pad36 (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_cfg(pad36_config),
    .i_periph_ctrl(i_periph_ctrl[32:22]),
    .i_fabric_ctrl(i_fabric_ctrl[32:22]),
    .i_engine_ctrl(i_engine_ctrl[32:22]),
    .o_pad_ctrl(o_pad_ctrl[32:22]),
    .o_output_function_select(o_output_function_select[5:4])
  );

  pad_route #(.ENGINE_OVERRIDE(1'b1)) u_pad37 (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_cfg(pad37_config),
    .i_periph_ctrl(i_periph_ctrl[43:33]),
    .i_fabric_ctrl(i_fabric_ctrl[43:33]),
    .i_engine_ctrl(i_engine_ctrl[43:33]),
    .o_pad_ctrl(o_pad_ctrl[43:33]),
    .o_output_function_select(o_output_function_select[7:6])
  );

endmodule // pad_ctrl_bank

// ===== dv/pad_ctrl_checker.sv
// Port assertions for the pad configuration bank.
// Assumes bind onto pad_ctrl_bank, one clock domain.
`timescale 1ns/1ps
module pad_ctrl_checker (
  input wire i_clk_sys,
  input wire i_nrst,
  input wire [11:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [31:0] o_rdata,
  input wire [43:0] i_periph_ctrl,
  input wire [43:0] i_fabric_ctrl,
  input wire [43:0] i_engine_ctrl,
  input wire [43:0] o_pad_ctrl,
  input wire [7:0] o_output_function_select
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  AST_RSVD: assert property (o_rdata[31:13] == 0 && !o_rdata[2])
    else $error("reserved bits set");
  AST_UNMAP: assert property ($past(i_rd) && ($past(i_addr) < 12'h088 ||
    $past(i_addr) > 12'h094 || $past(i_addr[1:0]) != 0) |-> o_rdata == 0)
    else $error("unmapped read not zero");
  AST_FUNC34: assert property (i_wr && i_addr == 12'h088 |->
    ##2 o_output_function_select[1:0] == $past(i_wdata[1:0], 2))
    else $error("pad34 function");
  AST_FUNC37: assert property (i_wr && i_addr == 12'h094 |->
    ##2 o_output_function_select[7:6] == $past(i_wdata[1:0], 2))
    else $error("pad37 function");
  AST_LOCAL35: assert property (i_wr && i_addr == 12'h08c && i_wdata[4:3] == 0 &&
    i_wdata[1:0] != 2 |-> ##2 o_pad_ctrl[21:11] == {3'h0, $past(i_wdata[12:5], 2)})
    else $error("pad35 local bundle");
  AST_ENGINE36: assert property (i_wr && i_addr == 12'h090 && i_wdata[1:0] == 2 |->
    ##2 o_pad_ctrl[32:22] == $past(i_engine_ctrl[32:22])) else $error("pad36 engine");
  AST_PERIPH34: assert property (i_wr && i_addr == 12'h088 && i_wdata[4:3] == 1 |->
    ##2 o_pad_ctrl[10:0] == $past(i_periph_ctrl[10:0])) else $error("pad34 periph");
  AST_FABRIC37: assert property (i_wr && i_addr == 12'h094 && i_wdata[4:3] == 2 &&
    i_wdata[1:0] != 2 |-> ##2 o_pad_ctrl[43:33] == $past(i_fabric_ctrl[43:33]))
    else $error("pad37 fabric");
endmodule // pad_ctrl_checker
bind pad_ctrl_bank pad_ctrl_checker pad_ctrl_checker_inst (.i_clk_sys(i_clk_sys),
  .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_periph_ctrl(i_periph_ctrl), .i_fabric_ctrl(i_fabric_ctrl),
  .i_engine_ctrl(i_engine_ctrl), .o_pad_ctrl(o_pad_ctrl),
  .o_output_function_select(o_output_function_select));

// ===== dv/pad_sources.sv
// Peripheral, fabric and engine sources of pad bundles.
// Assumes one clock; values change every cycle to expose stale routing.
`timescale 1ns/1ps
module pad_sources (
  input wire i_clk_sys,
  output logic [43:0] o_periph_ctrl,
  output logic [43:0] o_fabric_ctrl,
  output logic [43:0] o_engine_ctrl
);
  initial {o_periph_ctrl, o_fabric_ctrl, o_engine_ctrl} = '0;
  always @(posedge i_clk_sys) begin
    o_periph_ctrl <= 44'({$urandom, $urandom});
    o_fabric_ctrl <= 44'({$urandom, $urandom});
    o_engine_ctrl <= 44'({$urandom, $urandom});
  end
endmodule // pad_sources

// ===== dv/tb_pad_ctrl_bank.sv
// Self-checking bench for the pad configuration bank.
// Assumes pad_sources drives the three bundle inputs.
`timescale 1ns/1ps
module tb_pad_ctrl_bank;
  logic i_clk_sys = 0, i_nrst = 0, i_wr = 0, i_rd = 0;
  logic [11:0] i_addr = 12'h000;
  logic [31:0] i_wdata = 32'h0, v;
  logic [10:0] p, f, e;
  wire [31:0] o_rdata;
  wire [43:0] per, fab, eng, o_pad_ctrl;
  wire [7:0] o_output_function_select;
  int failures = 0, total_checks = 0, k, n;
  always #5 i_clk_sys = ~i_clk_sys;
  pad_sources pad_sources_inst (.i_clk_sys(i_clk_sys), .o_periph_ctrl(per),
    .o_fabric_ctrl(fab), .o_engine_ctrl(eng));
  pad_ctrl_bank pad_ctrl_bank_inst (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_periph_ctrl(per),
    .i_fabric_ctrl(fab), .i_engine_ctrl(eng), .o_pad_ctrl(o_pad_ctrl),
    .o_output_function_select(o_output_function_select));
  // ****
  // Expectation and bus helpers
  // ****
  function automatic logic [10:0] route(int k, logic [31:0] c, logic [10:0] p, f, e);
    if (k > 0 && c[1:0] == 2'h2) return e;
    case (c[4:3])
      2'h0: return {3'h0, c[12:5]};
      2'h1: return p;
      2'h2: return f;
      default: return 11'h001;
    endcase
  endfunction
  task check(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task check_pad(input logic [31:0] got, exp);
    check(got, exp);
  endtask
  task check_func(input logic [31:0] got, exp);
    check(got, exp);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    i_addr <= a; i_wdata <= d; i_wr <= 1;
    @(posedge i_clk_sys) i_wr <= 0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp);
    i_addr <= a; i_rd <= 1;
    @(posedge i_clk_sys) i_rd <= 0;
    #1 check(o_rdata, exp);
    @(posedge i_clk_sys);
  endtask
  // Output lags the inputs by one registered stage
  task pads(input int k, input logic [31:0] c);
    @(posedge i_clk_sys) #1;
    p = per[11*k +: 11]; f = fab[11*k +: 11]; e = eng[11*k +: 11];
    @(posedge i_clk_sys) #1;
    check_pad(32'(o_pad_ctrl[11*k +: 11]), 32'(route(k, c, p, f, e)));
    check_func(32'(o_output_function_select[2*k +: 2]), 32'(c[1:0]));
    @(posedge i_clk_sys);
  endtask
  task print_verdict;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    v = $urandom(32'hc7a6);
    repeat (2) @(posedge i_clk_sys);
    i_nrst <= 1;
    repeat (2) @(posedge i_clk_sys);
    #1 check_pad(32'(o_pad_ctrl[21:11]), 32'h009);
    @(posedge i_clk_sys);
    for (k = 0; k < 4; k++) rd(12'h088 + 12'(4*k), k[0] ? 32'h120 : 32'h128);
    rd(12'h084, 32'h0);
    wr(12'h088, 32'h1a);
    pads(0, 32'h1a);
    for (n = 0; n < 150; n++) begin
      k = $urandom % 4;
      v = $urandom;
      wr(12'h088 + 12'(4*k), v);
      rd(12'h088 + 12'(4*k), v & 32'h00001ffb);
      wr(12'h098, ~v);
      pads(k, v);
    end
    // Mid-run reset: outputs park, registers return to defaults
    i_nrst <= 0;
    @(posedge i_clk_sys) #1;
    for (k = 0; k < 4; k++) check_pad(32'(o_pad_ctrl[11*k +: 11]), 32'h001);
    check_func(32'(o_output_function_select), 32'h0);
    @(posedge i_clk_sys) i_nrst <= 1;
    for (k = 0; k < 4; k++) rd(12'h088 + 12'(4*k), k[0] ? 32'h120 : 32'h128);
    pads(3, 32'h120);
    print_verdict;
  end
endmodule // tb_pad_ctrl_bank
